//--- pts_pkg.sv
package pts_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [5:0] ADDR_CTRL   = 6'h00;
  localparam logic [5:0] ADDR_COMM   = 6'h04;
  localparam logic [5:0] ADDR_INDEX  = 6'h08;
  localparam logic [5:0] ADDR_POS    = 6'h0C;
  localparam logic [5:0] ADDR_SPEED  = 6'h10;
  localparam logic [5:0] ADDR_ACC    = 6'h14;
  localparam logic [5:0] ADDR_DEC    = 6'h18;
  localparam logic [5:0] ADDR_DWELL  = 6'h1C;
  localparam logic [5:0] ADDR_AUX    = 6'h20;
  localparam logic [5:0] ADDR_MCODE  = 6'h24;
  localparam logic [5:0] ADDR_STATUS = 6'h28;

  // control register fields
  localparam int CTRL_PIN2_EN = 0;
  localparam int CTRL_PIN3_EN = 1;
  localparam int CTRL_DIR     = 2;
  localparam int CTRL_UNIT_LO = 4;
  localparam int CTRL_STM_LO  = 8;
  localparam logic [11:0] CTRL_RESET = 12'h000;
  // communication select register: bit 8 routes the select code
  localparam int COMM_USE = 8;

  localparam logic [1:0] UNIT_MM    = 2'h0;
  localparam logic [1:0] UNIT_INCH  = 2'h1;
  localparam logic [1:0] UNIT_DEG   = 2'h2;
  localparam logic [1:0] UNIT_PULSE = 2'h3;

  // ****************************************
  // value limits
  // ****************************************
  localparam int POS_MAX    = 999999;
  localparam int POS_MIN    = -999999;
  localparam int TIME_MAX   = 20000;
  localparam int AUX_MAX    = 11;
  localparam int MCODE_MAX  = 99;
  localparam int ENTRY_MIN  = 1;
  localparam int ENTRY_MAX  = 31;
  localparam logic signed [20:0] DEG_REV  = 21'sh057E40;
  localparam logic        [18:0] DEG_HALF = 19'h2BF20;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic signed [20:0] pos;
    logic [15:0]        speed;
    logic [14:0]        acc;
    logic [14:0]        dec;
    logic [14:0]        dwell;
    logic [3:0]         aux;
    logic [3:0]         m_tens;
    logic [3:0]         m_ones;
  } pts_entry_s;

  typedef struct packed {
    logic [4:0]         entry;
    logic               home;
    logic               absolute;
    logic               ccw;
    logic               forward;
    logic [1:0]         unit;
    logic [1:0]         feed_length_exponent;
    logic signed [20:0] pos;
    logic [15:0]        speed;
    logic [14:0]        acc;
    logic [14:0]        dec;
    logic [14:0]        dwell;
    logic [3:0]         m_tens;
    logic [3:0]         m_ones;
  } pts_cmd_s;

endpackage : pts_pkg

//--- pts_sync.sv
`timescale 1ns/1ns
module pts_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= '0;
      o_q    <= '0;
    end else begin
      meta_q <= i_d;
      o_q    <= meta_q;
    end
  end
endmodule : pts_sync

//--- pts_select.sv
// Design decisions made here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ns
module pts_select #(
  parameter int SPEED_MAX = 6000
) (
  input  wire logic             I_CLOCK,
  input  wire logic             I_RESET,
  input  wire logic [5:0]       I_AXI_AWADDR,
  input  wire logic             I_AXI_AWVALID,
  output logic                  O_AXI_AWREADY,
  input  wire logic [31:0]      I_AXI_WDATA,
  input  wire logic [3:0]       I_AXI_WSTRB,
  input  wire logic             I_AXI_WVALID,
  output logic                  O_AXI_WREADY,
  output logic [1:0]            O_AXI_BRESP,
  output logic                  O_AXI_BVALID,
  input  wire logic             I_AXI_BREADY,
  input  wire logic [5:0]       I_AXI_ARADDR,
  input  wire logic             I_AXI_ARVALID,
  output logic                  O_AXI_ARREADY,
  output logic [31:0]           O_AXI_RDATA,
  output logic [1:0]            O_AXI_RRESP,
  output logic                  O_AXI_RVALID,
  input  wire logic             I_AXI_RREADY,
  input  wire logic [3:0]       I_ENTRY_SELECT,
  input  wire logic             I_FORWARD_START,
  input  wire logic             I_REVERSE_START,
  input  wire logic [18:0]      I_CUR_DEG,
  input  wire logic             I_MOVE_DONE,
  output logic                  O_START,
  output logic                  O_BUSY,
  output pts_pkg::pts_cmd_s     O_CMD
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic int clampi(input int v, input int lo, input int hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clampi

  function automatic logic is_abs(input logic [3:0] aux);
    return (aux[1] == 1'b0);
  endfunction : is_abs

  function automatic logic [18:0] deg_mod(input logic signed [20:0] v);
    logic signed [20:0] r;
    r = v % pts_pkg::DEG_REV;
    if (r < 0) r = r + pts_pkg::DEG_REV;
    return r[18:0];
  endfunction : deg_mod

  // ****************************************
  // state
  // ****************************************
  pts_pkg::pts_entry_s tbl_q [0:31];
  logic [11:0]  ctrl_q;
  logic [8:0]   comm_q;
  logic [4:0]   idx_q;
  logic         aw_have_q;
  logic         w_have_q;
  logic [5:0]   awaddr_q;
  logic [31:0]  wdata_q;
  logic [3:0]   wstrb_q;
  logic         bvalid_q;
  logic [1:0]   bresp_q;
  logic         rvalid_q;
  logic [31:0]  rdata_q;
  logic [1:0]   rresp_q;
  logic         busy_q;
  logic         start_q;
  logic         fwd_prev_q;
  logic         rev_prev_q;
  pts_pkg::pts_cmd_s cmd_q;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [5:0] pins_s;

  pts_sync #(.W(6)) u_sync (
    .i_clk (I_CLOCK),
    .i_rst (I_RESET),
    .i_d   ({I_REVERSE_START, I_FORWARD_START, I_ENTRY_SELECT}),
    .o_q   (pins_s)
  );

  wire       fwd_s   = pins_s[4];
  wire       rev_s   = pins_s[5];
  wire       use_comm = comm_q[pts_pkg::COMM_USE];
  wire       pin2_en = ctrl_q[pts_pkg::CTRL_PIN2_EN];
  wire       pin3_en = ctrl_q[pts_pkg::CTRL_PIN3_EN];
  wire       dir_short = ctrl_q[pts_pkg::CTRL_DIR];
  wire [1:0] unit    = ctrl_q[pts_pkg::CTRL_UNIT_LO +: 2];
  wire [1:0] feed_length_exponent     = ctrl_q[pts_pkg::CTRL_STM_LO +: 2];

  // ****************************************
  // entry selection and target resolution
  // ****************************************
  // bit 4 has no pin; bits 2 and 3 are gated until enabled
  wire [4:0] pin_sel = {1'b0, pin3_en & pins_s[3], pin2_en & pins_s[2],
                        pins_s[1:0]};
  wire [4:0] sel     = use_comm ? comm_q[4:0] : pin_sel;
  wire pts_pkg::pts_entry_s ent = tbl_q[sel];
  wire        ent_abs  = is_abs(ent.aux);
  wire        is_deg   = (unit == pts_pkg::UNIT_DEG);
  wire [18:0] tgt_deg  = deg_mod(ent.pos);
  wire [18:0] ccw_dist = (tgt_deg >= I_CUR_DEG) ? (tgt_deg - I_CUR_DEG) :
                         19'(tgt_deg + pts_pkg::DEG_REV[18:0] - I_CUR_DEG);
  wire        short_ccw = (ccw_dist <= pts_pkg::DEG_HALF);
  wire        sign_ccw  = ~ent.pos[20];
  wire        fwd_rise  = fwd_s & ~fwd_prev_q;
  wire        rev_rise  = rev_s & ~rev_prev_q;
  wire        start_ok  = (fwd_rise | rev_rise) & ~busy_q;
  wire        dir_ccw   = (is_deg & ent_abs) ?
                          (dir_short ? short_ccw : sign_ccw) : fwd_rise;

  pts_pkg::pts_cmd_s cmd_d;
  always_comb begin
    cmd_d          = cmd_q;
    cmd_d.entry    = sel;
    cmd_d.home     = (sel == 5'h00);
    cmd_d.absolute = ent_abs;
    cmd_d.ccw      = dir_ccw;
    cmd_d.forward  = fwd_rise;
    cmd_d.unit     = unit;
    cmd_d.feed_length_exponent      = feed_length_exponent;
    cmd_d.pos      = ent.pos;
    cmd_d.speed    = ent.speed;
    cmd_d.acc      = ent.acc;
    cmd_d.dec      = ent.dec;
    cmd_d.dwell    = ent.dwell;
    cmd_d.m_tens   = ent.m_tens;
    cmd_d.m_ones   = ent.m_ones;
  end

  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      busy_q     <= 1'b0;
      start_q    <= 1'b0;
      fwd_prev_q <= 1'b0;
      rev_prev_q <= 1'b0;
      cmd_q      <= '0;
    end else begin
      fwd_prev_q <= fwd_s;
      rev_prev_q <= rev_s;
      start_q    <= start_ok;
      if (start_ok) begin
        busy_q <= 1'b1;
        cmd_q  <= cmd_d;
      end else if (I_MOVE_DONE) begin
        busy_q <= 1'b0;
      end
    end
  end

  assign O_START = start_q;
  assign O_BUSY  = busy_q;
  assign O_CMD   = cmd_q;

  // ****************************************
  // register bus: write path
  // ****************************************
  wire wr_go    = aw_have_q & w_have_q & ~bvalid_q;
  wire full_stb = (wstrb_q == 4'hF);
  wire wr_tbl   = (awaddr_q >= pts_pkg::ADDR_POS) && (awaddr_q <= pts_pkg::ADDR_MCODE);
  wire wr_map   = wr_tbl || (awaddr_q == pts_pkg::ADDR_CTRL) ||
                  (awaddr_q == pts_pkg::ADDR_COMM) || (awaddr_q == pts_pkg::ADDR_INDEX);
  wire wr_ok    = wr_map & full_stb;
  wire integer wv = signed'(wdata_q);
  wire pts_pkg::pts_entry_s cur = tbl_q[idx_q];

  assign O_AXI_AWREADY = ~aw_have_q & ~bvalid_q;
  assign O_AXI_WREADY  = ~w_have_q & ~bvalid_q;
  assign O_AXI_BVALID  = bvalid_q;
  assign O_AXI_BRESP   = bresp_q;

  // merge a written value into the indexed entry, clamped to its range
  pts_pkg::pts_entry_s ent_w;
  always_comb begin
    int m;
    m     = clampi(wv, 0, pts_pkg::MCODE_MAX);
    ent_w = cur;
    unique case (awaddr_q)
      pts_pkg::ADDR_POS: ent_w.pos = 21'(clampi(wv, is_abs(cur.aux) ? pts_pkg::POS_MIN : 0,
                                                pts_pkg::POS_MAX));
      pts_pkg::ADDR_SPEED: ent_w.speed = 16'(clampi(wv, 0, SPEED_MAX));
      pts_pkg::ADDR_ACC:   ent_w.acc   = 15'(clampi(wv, 0, pts_pkg::TIME_MAX));
      pts_pkg::ADDR_DEC:   ent_w.dec   = 15'(clampi(wv, 0, pts_pkg::TIME_MAX));
      pts_pkg::ADDR_DWELL: ent_w.dwell = 15'(clampi(wv, 0, pts_pkg::TIME_MAX));
      pts_pkg::ADDR_AUX: begin
        ent_w.aux = 4'(clampi(wv, 0, pts_pkg::AUX_MAX));
        if (!is_abs(ent_w.aux) && cur.pos < 0) ent_w.pos = '0;
      end
      pts_pkg::ADDR_MCODE: begin
        ent_w.m_tens = 4'(m / 10);
        ent_w.m_ones = 4'(m % 10);
      end
      default: ent_w = cur;
    endcase
  end

  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
      bvalid_q  <= 1'b0;
      bresp_q   <= pts_pkg::RESP_OKAY;
    end else begin
      if (I_AXI_AWVALID && O_AXI_AWREADY) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= I_AXI_AWADDR;
      end
      if (I_AXI_WVALID && O_AXI_WREADY) begin
        w_have_q <= 1'b1;
        wdata_q  <= I_AXI_WDATA;
        wstrb_q  <= I_AXI_WSTRB;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_ok ? pts_pkg::RESP_OKAY : pts_pkg::RESP_SLVERR;
      end else if (bvalid_q && I_AXI_BREADY) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      ctrl_q <= pts_pkg::CTRL_RESET;
      comm_q <= '0;
      idx_q  <= 5'h01;
    end else if (wr_go && wr_ok) begin
      if (awaddr_q == pts_pkg::ADDR_CTRL) ctrl_q <= wdata_q[11:0];
      if (awaddr_q == pts_pkg::ADDR_COMM) comm_q <= {wdata_q[8], wdata_q[7:5] & 3'h0, wdata_q[4:0]};
      if (awaddr_q == pts_pkg::ADDR_INDEX)
        idx_q <= 5'(clampi(wv, pts_pkg::ENTRY_MIN, pts_pkg::ENTRY_MAX));
    end
  end

  // entry 0 stays empty: it names home return, not a table row
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      for (int i = 0; i < 32; i++) tbl_q[i] <= '0;
    end else if (wr_go && wr_ok && wr_tbl) begin
      tbl_q[idx_q] <= ent_w;
    end
  end

  // ****************************************
  // register bus: read path
  // ****************************************
  logic [31:0] rd_w;
  logic        rd_err;
  always_comb begin
    rd_w   = '0;
    rd_err = 1'b0;
    unique case (I_AXI_ARADDR)
      pts_pkg::ADDR_CTRL:   rd_w = {20'h00000, ctrl_q};
      pts_pkg::ADDR_COMM:   rd_w = {23'h000000, comm_q};
      pts_pkg::ADDR_INDEX:  rd_w = {27'h0000000, idx_q};
      pts_pkg::ADDR_POS:    rd_w = 32'(cur.pos);
      pts_pkg::ADDR_SPEED:  rd_w = {16'h0000, cur.speed};
      pts_pkg::ADDR_ACC:    rd_w = {17'h00000, cur.acc};
      pts_pkg::ADDR_DEC:    rd_w = {17'h00000, cur.dec};
      pts_pkg::ADDR_DWELL:  rd_w = {17'h00000, cur.dwell};
      pts_pkg::ADDR_AUX:    rd_w = {28'h0000000, cur.aux};
      pts_pkg::ADDR_MCODE:  rd_w = {24'h000000, cur.m_tens, cur.m_ones};
      pts_pkg::ADDR_STATUS: rd_w = {18'h00000, busy_q, cmd_q.ccw, cmd_q.absolute,
                                    cmd_q.home, sel, cmd_q.entry};
      default:              rd_err = 1'b1;
    endcase
  end

  assign O_AXI_ARREADY = ~rvalid_q;
  assign O_AXI_RVALID  = rvalid_q;
  assign O_AXI_RDATA   = rdata_q;
  assign O_AXI_RRESP   = rresp_q;

  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= pts_pkg::RESP_OKAY;
    end else if (I_AXI_ARVALID && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_w;
      rresp_q  <= rd_err ? pts_pkg::RESP_SLVERR : pts_pkg::RESP_OKAY;
    end else if (rvalid_q && I_AXI_RREADY) begin
      rvalid_q <= 1'b0;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_RESET);

  sequence s_start_taken;
    start_ok ##1 start_q;
  endsequence

  AST_HOME_ZERO: assert property (start_q |-> (O_CMD.home == (O_CMD.entry == 5'h00)))
    else $error("home flag does not match entry zero");
  AST_PIN_GATE: assert property (!use_comm && !pin2_en |-> !sel[2] && !sel[4])
    else $error("gated select bit reached the entry number");
  AST_BIT4_COMM: assert property (sel[4] |-> use_comm && comm_q[4])
    else $error("select bit 4 set without the communication path");
  AST_ABS_AUX: assert property (s_start_taken |-> O_CMD.absolute == $past(is_abs(ent.aux)))
    else $error("absolute flag disagrees with aux code");
  AST_POS_RANGE: assert property (cur.pos <= 21'sd999999 && cur.pos >= -21'sd999999
                                  && (is_abs(cur.aux) || cur.pos >= 0))
    else $error("stored position outside its range");
  AST_HOLD: assert property (busy_q && !I_MOVE_DONE |=> $stable(O_CMD) && busy_q)
    else $error("command changed during a move");
  AST_SIGN_DIR: assert property (start_ok && is_deg && ent_abs && !dir_short
                                 |=> O_CMD.ccw == !O_CMD.pos[20])
    else $error("sign mode direction wrong");
  AST_SHORT_DIR: assert property (start_ok && is_deg && ent_abs && dir_short
                                  |=> O_CMD.ccw == $past(ccw_dist) <= pts_pkg::DEG_HALF)
    else $error("shortest path direction wrong");
  AST_MCODE: assert property (O_CMD.m_tens <= 4'h9 && O_CMD.m_ones <= 4'h9)
    else $error("M code digit above nine");
  AST_BHOLD: assert property (bvalid_q && !I_AXI_BREADY |=> bvalid_q && $stable(bresp_q))
    else $error("write response dropped early");
  AST_GATE3: assert property (!use_comm && !pin3_en |-> !sel[3])
    else $error("gated select bit 3 reached the entry number");
  AST_IDX_RANGE: assert property (idx_q != 5'h00)
    else $error("edited entry index left the table");
  AST_DEG_WRAP: assert property (tgt_deg < pts_pkg::DEG_REV[18:0])
    else $error("degree target not reduced to one revolution");
  AST_BUSY_SET: assert property (s_start_taken |-> busy_q
                                 && O_CMD.entry == $past(sel))
    else $error("start did not latch the selected entry");
  AST_INC_POS: assert property (start_q && !O_CMD.absolute |-> !O_CMD.pos[20])
    else $error("incremental distance is negative");
  AST_HOME_DATA: assert property (start_q && O_CMD.home |-> O_CMD.pos == '0)
    else $error("home return carries position data");

endmodule : pts_select

//--- pts_ctrl_model.sv
`timescale 1ns/1ns
module pts_ctrl_model (
  input  wire logic       i_clk,
  input  wire logic       i_start,
  output logic      [3:0] o_select,
  output logic            o_forward,
  output logic            o_reverse,
  output logic            o_done
);
  logic got_start = 1'b0;
  logic one_shot  = 1'b0;

  initial begin
    o_select  = 4'h0;
    o_forward = 1'b0;
    o_reverse = 1'b0;
    o_done    = 1'b0;
  end

  // ****************************************
  // select an entry, then pulse one start pin
  // ****************************************
  task automatic run(input logic [3:0] sel, input logic fwd);
    int n;
    @(posedge i_clk);
    o_select <= sel;
    repeat (4) @(posedge i_clk);
    o_forward <= fwd;
    o_reverse <= !fwd;
    got_start = 1'b0;
    n = 0;
    while (!got_start && n < 12) begin
      @(negedge i_clk);
      got_start = i_start;
      n++;
    end
    @(negedge i_clk);
    one_shot = got_start && !i_start;
    @(posedge i_clk);
    o_forward <= 1'b0;
    o_reverse <= 1'b0;
  endtask : run

  task automatic finish_move();
    @(posedge i_clk);
    o_done <= 1'b1;
    @(posedge i_clk);
    o_done <= 1'b0;
    repeat (2) @(posedge i_clk);
  endtask : finish_move
endmodule : pts_ctrl_model

//--- pts_select_tb.sv
`timescale 1ns/1ns
module pts_select_tb;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic        [5:0] awaddr = 6'h00;
  logic        [5:0] araddr = 6'h00;
  logic       [31:0] wdata = 32'h0;
  logic        [3:0] wstrb = 4'hF;
  logic              awvalid = 1'b0;
  logic              wvalid = 1'b0;
  logic              bready = 1'b0;
  logic              arvalid = 1'b0;
  logic              rready = 1'b0;
  logic       [18:0] cur_deg = 19'h0;
  logic              awready, wready, bvalid, arready, rvalid, start, busy;
  logic              fwd, rev, done;
  logic        [3:0] sel;
  logic        [1:0] bresp, rresp;
  logic       [31:0] rdata;
  pts_pkg::pts_cmd_s cmd;
  int                errors = 0;
  int                checks_done = 0;
  int                cycles = 0;
  logic       [11:0] deg_ctl [8] = '{12'h020, 12'h020, 12'h020, 12'h020,
                                     12'h024, 12'h024, 12'h024, 12'h024};
  logic       [18:0] deg_cur [8] = '{19'h0, 19'h0, 19'h0, 19'h0,
                                     19'h15F90, 19'h0, 19'h0, 19'h0};
  logic       [31:0] deg_pos [8] = '{32'hFFFA81C0, 32'h00057E40, 32'h0, 32'hFFFEA070,
                                     32'h00041EB0, 32'h00041EB0, 32'hFFFEA070, 32'h00015F90};
  logic              deg_ccw [8] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
  logic        [3:0] aux_code [8] = '{4'h0, 4'h1, 4'h8, 4'h9, 4'h2, 4'h3, 4'hA, 4'hB};

  always #20 clk = ~clk;

  pts_select uut (
    .I_CLOCK(clk), .I_RESET(rst),
    .I_AXI_AWADDR(awaddr), .I_AXI_AWVALID(awvalid), .O_AXI_AWREADY(awready),
    .I_AXI_WDATA(wdata), .I_AXI_WSTRB(wstrb), .I_AXI_WVALID(wvalid), .O_AXI_WREADY(wready),
    .O_AXI_BRESP(bresp), .O_AXI_BVALID(bvalid), .I_AXI_BREADY(bready),
    .I_AXI_ARADDR(araddr), .I_AXI_ARVALID(arvalid), .O_AXI_ARREADY(arready),
    .O_AXI_RDATA(rdata), .O_AXI_RRESP(rresp), .O_AXI_RVALID(rvalid), .I_AXI_RREADY(rready),
    .I_ENTRY_SELECT(sel), .I_FORWARD_START(fwd), .I_REVERSE_START(rev),
    .I_CUR_DEG(cur_deg), .I_MOVE_DONE(done),
    .O_START(start), .O_BUSY(busy), .O_CMD(cmd)
  );

  pts_ctrl_model u_ctrl (
    .i_clk(clk), .i_start(start), .o_select(sel),
    .o_forward(fwd), .o_reverse(rev), .o_done(done)
  );

  // ****************************************
  // bus and comparison helpers
  // ****************************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta;
    logic tw;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while ((awvalid && !ta) || (wvalid && !tw));
    do @(negedge clk); while (!bvalid);
    check("bresp", {30'h0, bresp}, {30'h0, er});
    @(posedge clk);
    bready <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [5:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge clk); while (!(arvalid && arready));
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (!rvalid);
    check("rdata", rdata, ed);
    check("rresp", {30'h0, rresp}, {30'h0, er});
    @(posedge clk);
    rready <= 1'b0;
  endtask : rd_chk

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs();
    rd_chk(pts_pkg::ADDR_CTRL, 32'h0, 2'h0);
    rd_chk(pts_pkg::ADDR_INDEX, 32'h1, 2'h0);
    rd_chk(6'h2C, 32'h0, 2'h2);
    wr(pts_pkg::ADDR_STATUS, 32'hFFFFFFFF, 2'h2);
    wr(pts_pkg::ADDR_INDEX, 32'h0, 2'h0);
    rd_chk(pts_pkg::ADDR_INDEX, 32'h1, 2'h0);
    wr(pts_pkg::ADDR_INDEX, 32'h28, 2'h0);
    rd_chk(pts_pkg::ADDR_INDEX, 32'h1F, 2'h0);
    wr(pts_pkg::ADDR_INDEX, 32'h1, 2'h0);
    wstrb <= 4'h3;
    wr(pts_pkg::ADDR_INDEX, 32'h5, 2'h2);
    wstrb <= 4'hF;
    rd_chk(pts_pkg::ADDR_INDEX, 32'h1, 2'h0);
  endtask : t_regs

  task automatic t_table();
    wr(pts_pkg::ADDR_AUX, 32'h0, 2'h0);
    wr(pts_pkg::ADDR_POS, 32'h001E8480, 2'h0);
    rd_chk(pts_pkg::ADDR_POS, 32'h000F423F, 2'h0);
    wr(pts_pkg::ADDR_POS, 32'hFFE17B80, 2'h0);
    rd_chk(pts_pkg::ADDR_POS, 32'hFFF0BDC1, 2'h0);
    wr(pts_pkg::ADDR_AUX, 32'h2, 2'h0);
    rd_chk(pts_pkg::ADDR_POS, 32'h0, 2'h0);
    wr(pts_pkg::ADDR_ACC, 32'h7530, 2'h0);
    rd_chk(pts_pkg::ADDR_ACC, 32'h4E20, 2'h0);
    wr(pts_pkg::ADDR_MCODE, 32'h39, 2'h0);
    rd_chk(pts_pkg::ADDR_MCODE, 32'h57, 2'h0);
    wr(pts_pkg::ADDR_SPEED, 32'h64, 2'h0);
    wr(pts_pkg::ADDR_DEC, 32'h7, 2'h0);
    wr(pts_pkg::ADDR_DWELL, 32'h5, 2'h0);
    wr(pts_pkg::ADDR_POS, 32'h7B, 2'h0);
    u_ctrl.run(4'h1, 1'b1);
    check("pos", cmd.pos, 32'h7B);
    check("speed", cmd.speed, 32'h64);
    check("acc", cmd.acc, 32'h4E20);
    check("dec", cmd.dec, 32'h7);
    check("dwell", cmd.dwell, 32'h5);
    check("mcode", {cmd.m_tens, cmd.m_ones}, 32'h57);
    check("absolute", cmd.absolute, 32'h0);
    u_ctrl.finish_move();
  endtask : t_table

  task automatic t_select();
    u_ctrl.run(4'hF, 1'b1);
    check("entry", cmd.entry, 32'h3);
    check("pulse", {u_ctrl.one_shot, busy, cmd.forward}, 32'h7);
    u_ctrl.run(4'h1, 1'b1);
    check("restart", u_ctrl.got_start, 32'h0);
    check("held", cmd.entry, 32'h3);
    u_ctrl.finish_move();
    check("idle", busy, 32'h0);
    wr(pts_pkg::ADDR_CTRL, 32'h303, 2'h0);
    u_ctrl.run(4'hC, 1'b0);
    check("entry", cmd.entry, 32'hC);
    check("fwd_stm", {cmd.forward, cmd.feed_length_exponent}, 32'h3);
    rd_chk(pts_pkg::ADDR_STATUS, 32'h298C, 2'h0);
    u_ctrl.finish_move();
    wr(pts_pkg::ADDR_COMM, 32'h113, 2'h0);
    u_ctrl.run(4'h0, 1'b1);
    check("entry", cmd.entry, 32'h13);
    u_ctrl.finish_move();
    wr(pts_pkg::ADDR_COMM, 32'h0, 2'h0);
    u_ctrl.run(4'h0, 1'b1);
    check("home", {cmd.home, cmd.entry}, 32'h20);
    u_ctrl.finish_move();
    wr(pts_pkg::ADDR_CTRL, 32'h0, 2'h0);
  endtask : t_select

  task automatic t_aux();
    for (int k = 0; k < 8; k++) begin
      wr(pts_pkg::ADDR_AUX, {28'h0, aux_code[k]}, 2'h0);
      u_ctrl.run(4'h1, 1'b1);
      check("absolute", cmd.absolute, {31'h0, k < 4});
      u_ctrl.finish_move();
    end
  endtask : t_aux

  task automatic t_deg();
    wr(pts_pkg::ADDR_AUX, 32'h0, 2'h0);
    for (int k = 0; k < 8; k++) begin
      wr(pts_pkg::ADDR_CTRL, {20'h0, deg_ctl[k]}, 2'h0);
      wr(pts_pkg::ADDR_POS, deg_pos[k], 2'h0);
      cur_deg <= deg_cur[k];
      u_ctrl.run(4'h1, 1'b0);
      check("ccw", {cmd.unit, cmd.ccw}, {29'h0, 2'h2, deg_ccw[k]});
      u_ctrl.finish_move();
    end
  endtask : t_deg

  task automatic t_reset();
    wr(pts_pkg::ADDR_CTRL, 32'h303, 2'h0);
    wr(pts_pkg::ADDR_INDEX, 32'h5, 2'h0);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_chk(pts_pkg::ADDR_CTRL, 32'h0, 2'h0);
    rd_chk(pts_pkg::ADDR_INDEX, 32'h1, 2'h0);
    check("reset_busy", {30'h0, busy, start}, 32'h0);
  endtask : t_reset

  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      finish_test();
    end
  end

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_table();
    t_select();
    t_aux();
    t_deg();
    t_reset();
    finish_test();
  end
endmodule : pts_select_tb
